// *** include/qgl_pkg.sv ***
// Purpose: shared constants of the quad gate latch with lockout
// Assumes: 40 MHz system clock, 32-bit AXI4-Lite register bus
// Notes: offsets are byte addresses of aligned words
package qgl_pkg;
  localparam int QGL_ADDR_W = 4;
  localparam logic [3:0] QGL_OFF_CTRL = 4'h0;
  localparam logic [3:0] QGL_OFF_STAT = 4'h4;
  localparam logic [3:0] QGL_OFF_IRQ = 4'h8;
  localparam logic [3:0] QGL_OFF_MASK = 4'hc;
  localparam int QGL_CTRL_FORCE_BIT = 0;
  localparam int QGL_ST_LOCK_BIT = 4;
  localparam int QGL_ST_PG_BIT = 5;
  localparam int QGL_ST_PUMP_BIT = 6;
  localparam int QGL_EV_W = 3;
  localparam int QGL_EV_LOCK_BIT = 0;
  localparam int QGL_EV_REL_BIT = 1;
  localparam int QGL_EV_SKIP_BIT = 2;
  localparam logic QGL_CTRL_RST = 1'h0;
  localparam logic [2:0] QGL_MASK_RST = 3'h0;
  localparam logic [2:0] QGL_STAT_RST = 3'h0;
  localparam logic [1:0] QGL_RESP_OKAY = 2'h0;
  localparam logic [1:0] QGL_RESP_SLVERR = 2'h2;
  localparam int QGL_CLK_HZ = 40_000_000;
  localparam int QGL_PUMP_HZ = 70_000;
  localparam int QGL_DIV_W = 10;
  localparam logic [9:0] QGL_PUMP_DIV = 10'(QGL_CLK_HZ / QGL_PUMP_HZ);
  localparam logic [9:0] QGL_PUMP_HALF = 10'(QGL_CLK_HZ / QGL_PUMP_HZ / 2);
endpackage

// *** src/qgl_top.sv ***
// Purpose: four-bit gate latch, undervoltage lockout, power good, pump pacing
// Assumes: comparator flags and pins are asynchronous to i_clk
// Notes: all pins pass a two-flop synchroniser; outputs are registered
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module qgl_top import qgl_pkg::*; #(
  parameter int ADDR_W = QGL_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_logic_level_a,
  input wire logic i_logic_level_b,
  input wire logic i_logic_level_c,
  input wire logic i_logic_level_d,
  input wire logic i_latch_gate_n,
  input wire logic i_supply_low,
  input wire logic i_rail_ready_threshold,
  input wire logic i_rail_above_reg,
  output logic o_gate_drive_a,
  output logic o_gate_drive_b,
  output logic o_gate_drive_c,
  output logic o_gate_drive_d,
  output logic o_power_good_flag,
  output logic o_pump_enable,
  output logic o_irq
);
  localparam int PUMP_CYC = int'(QGL_PUMP_DIV);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] lvl_m, lvl_s;
  logic gn_m, gn_s, low_m, low_s, rdy_m, rdy_s, abv_m, abv_s;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lvl_m <= 4'h0;
      lvl_s <= 4'h0;
      gn_m <= 1'h1;
      gn_s <= 1'h1;
      low_m <= 1'h1;
      low_s <= 1'h1;
      rdy_m <= 1'h0;
      rdy_s <= 1'h0;
      abv_m <= 1'h0;
      abv_s <= 1'h0;
    end else begin
      lvl_m <= {i_logic_level_d, i_logic_level_c, i_logic_level_b, i_logic_level_a};
      lvl_s <= lvl_m;
      gn_m <= i_latch_gate_n;
      gn_s <= gn_m;
      low_m <= i_supply_low;
      low_s <= low_m;
      rdy_m <= i_rail_ready_threshold;
      rdy_s <= rdy_m;
      abv_m <= i_rail_above_reg;
      abv_s <= abv_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // latch, lockout and power good
  logic ctrl_force_reg;
  logic [3:0] latch_reg, latch_next;
  logic pg_reg, pg_next, lock_d_reg, lock_all;

  always_comb begin
    lock_all = low_s | ~rdy_s | ctrl_force_reg;
    latch_next = latch_reg;
    if (lock_all) begin
      latch_next = 4'h0;
    end else if (!gn_s) begin
      latch_next = lvl_s;
    end
    pg_next = rdy_s & ~low_s;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      latch_reg <= 4'h0;
      pg_reg <= 1'h0;
      lock_d_reg <= 1'h1;
    end else begin
      latch_reg <= latch_next;
      pg_reg <= pg_next;
      lock_d_reg <= lock_all;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pump pacing: fixed period, a period is skipped when above regulation
  logic [QGL_DIV_W-1:0] div_reg, div_next;
  logic pump_reg, pump_next, tick;

  always_comb begin
    tick = (div_reg == QGL_PUMP_DIV - 10'h1);
    div_next = tick ? '0 : div_reg + 10'h1;
    pump_next = pump_reg;
    if (tick) begin
      pump_next = ~abv_s;
    end else if (div_reg == QGL_PUMP_HALF - 10'h1) begin
      pump_next = 1'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_reg <= '0;
      pump_reg <= 1'h0;
    end else begin
      div_reg <= div_next;
      pump_reg <= pump_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register bus and interrupts
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic w_strb_reg, w_strb_next;
  logic awrdy_reg, awrdy_next, wrdy_reg, wrdy_next, ardy_reg, ardy_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ctrl_force_next, irq_reg, irq_next;
  logic [QGL_EV_W-1:0] mask_reg, mask_next, stat_reg, stat_next, evt, clr;
  logic [31:0] status_word;

  always_comb begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    ctrl_force_next = ctrl_force_reg;
    mask_next = mask_reg;
    clr = '0;
    evt = '0;
    evt[QGL_EV_LOCK_BIT] = lock_all & ~lock_d_reg;
    evt[QGL_EV_REL_BIT] = ~lock_all & lock_d_reg;
    evt[QGL_EV_SKIP_BIT] = tick & abv_s;
    status_word = '0;
    status_word[3:0] = latch_reg;
    status_word[QGL_ST_LOCK_BIT] = lock_all;
    status_word[QGL_ST_PG_BIT] = pg_reg;
    status_word[QGL_ST_PUMP_BIT] = pump_reg;
    if (awrdy_reg && i_s_axi_awvalid) begin
      aw_have_next = 1'h1;
      aw_addr_next = i_s_axi_awaddr;
    end
    if (wrdy_reg && i_s_axi_wvalid) begin
      w_have_next = 1'h1;
      w_data_next = i_s_axi_wdata;
      w_strb_next = i_s_axi_wstrb[0];
    end
    if (bvalid_reg && i_s_axi_bready) begin
      bvalid_next = 1'h0;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      aw_have_next = 1'h0;
      w_have_next = 1'h0;
      bvalid_next = 1'h1;
      bresp_next = QGL_RESP_OKAY;
      case (aw_addr_reg)
        QGL_OFF_CTRL: begin
          if (w_strb_reg) ctrl_force_next = w_data_reg[QGL_CTRL_FORCE_BIT];
        end
        QGL_OFF_STAT: begin
        end
        QGL_OFF_IRQ: begin
          if (w_strb_reg) clr = w_data_reg[QGL_EV_W-1:0];
        end
        QGL_OFF_MASK: begin
          if (w_strb_reg) mask_next = w_data_reg[QGL_EV_W-1:0];
        end
        default: begin
          bresp_next = QGL_RESP_SLVERR;
        end
      endcase
    end
    // set wins over a clear in the same cycle
    stat_next = (stat_reg & ~clr) | evt;
    if (rvalid_reg && i_s_axi_rready) begin
      rvalid_next = 1'h0;
    end
    if (ardy_reg && i_s_axi_arvalid) begin
      rvalid_next = 1'h1;
      rresp_next = QGL_RESP_OKAY;
      rdata_next = '0;
      case (i_s_axi_araddr)
        QGL_OFF_CTRL: rdata_next[QGL_CTRL_FORCE_BIT] = ctrl_force_reg;
        QGL_OFF_STAT: rdata_next = status_word;
        QGL_OFF_IRQ: rdata_next[QGL_EV_W-1:0] = stat_reg;
        QGL_OFF_MASK: rdata_next[QGL_EV_W-1:0] = mask_reg;
        default: rresp_next = QGL_RESP_SLVERR;
      endcase
    end
    awrdy_next = ~aw_have_next & ~bvalid_next;
    wrdy_next = ~w_have_next & ~bvalid_next;
    ardy_next = ~rvalid_next;
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_have_reg <= 1'h0;
      aw_addr_reg <= '0;
      w_have_reg <= 1'h0;
      w_data_reg <= '0;
      w_strb_reg <= 1'h0;
      awrdy_reg <= 1'h0;
      wrdy_reg <= 1'h0;
      ardy_reg <= 1'h0;
      bvalid_reg <= 1'h0;
      bresp_reg <= QGL_RESP_OKAY;
      rvalid_reg <= 1'h0;
      rresp_reg <= QGL_RESP_OKAY;
      rdata_reg <= '0;
      ctrl_force_reg <= QGL_CTRL_RST;
      mask_reg <= QGL_MASK_RST;
      stat_reg <= QGL_STAT_RST;
      irq_reg <= 1'h0;
    end else begin
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awrdy_reg <= awrdy_next;
      wrdy_reg <= wrdy_next;
      ardy_reg <= ardy_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      ctrl_force_reg <= ctrl_force_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      irq_reg <= irq_next;
    end
  end

  assign o_s_axi_awready = awrdy_reg;
  assign o_s_axi_wready = wrdy_reg;
  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;
  assign o_s_axi_arready = ardy_reg;
  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rresp = rresp_reg;
  assign o_s_axi_rdata = rdata_reg;
  assign o_gate_drive_a = latch_reg[0];
  assign o_gate_drive_b = latch_reg[1];
  assign o_gate_drive_c = latch_reg[2];
  assign o_gate_drive_d = latch_reg[3];
  assign o_power_good_flag = pg_reg;
  assign o_pump_enable = pump_reg;
  assign o_irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  pass_through_a: assert property (!gn_s && !lock_all |=> latch_reg == $past(lvl_s))
    else $error("transparent latch did not follow inputs");
  hold_stable_a: assert property (gn_s && !lock_all |=> lock_all || $stable(latch_reg))
    else $error("held latch changed");
  capture_edge_a: assert property ($rose(gn_s) && !lock_all |=>
    lock_all || latch_reg == ($past(lock_all, 2) ? 4'h0 : $past(lvl_s, 2)))
    else $error("latch lost data captured at gate rise");
  lockout_clear_a: assert property (lock_all |=> latch_reg == 4'h0)
    else $error("outputs not low during lockout");
  stay_cleared_a: assert property ($past(lock_all) && !lock_all && gn_s |=> latch_reg == 4'h0)
    else $error("latch not cleared after lockout release");
  power_good_a: assert property ((!rdy_s || low_s) |=> !o_power_good_flag)
    else $error("power good high without rail");
  pump_skip_a: assert property (tick && abv_s |=> !o_pump_enable [*8])
    else $error("pump switched above regulation");
  pump_period_a: assert property (tick |-> ##[PUMP_CYC:PUMP_CYC] tick)
    else $error("pump period wrong");
  pump_start_a: assert property ($rose(o_pump_enable) |-> $past(tick) && !$past(abv_s))
    else $error("pump pulse not on synchronised tick");
  irq_level_a: assert property (|(stat_reg & mask_reg) |-> o_irq)
    else $error("interrupt not raised");

  lock_release_c: cover property ($fell(lock_all) ##[1:20] !gn_s);
  skip_c: cover property (tick && abv_s);
  capture_c: cover property ($rose(gn_s) && !lock_all);
  write_c: cover property (bvalid_reg && i_s_axi_bready);
endmodule
`default_nettype wire

// *** dv/qgl_host_model.sv ***
// Purpose: host logic that feeds the four data pins and the latch gate
// Assumes: one shared clock with the block
// Notes: pins change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module qgl_host_model (
  input wire logic i_clk,
  input wire logic [3:0] i_levels,
  input wire logic i_hold,
  output logic o_level_a,
  output logic o_level_b,
  output logic o_level_c,
  output logic o_level_d,
  output logic o_latch_gate_n
);
  always_ff @(posedge i_clk) begin
    {o_level_d, o_level_c, o_level_b, o_level_a} <= i_levels;
    // gate stays low unless latching is wanted
    o_latch_gate_n <= i_hold;
  end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: self-checking bench of the quad gate latch with lockout
// Assumes: 40 MHz clock, registers reached over AXI4-Lite
// Notes: outputs lag the pins by three edges, checks wait six
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qgl_pkg::*;
  logic clk, rstn, awv, wv, bre, arv, rre, hold, slow, rdy, abv;
  logic awr, wr, bv, arr, rv, pg, pump, irq, ga, gb, gc, gd, la, lb, lc, ld, gate_n;
  logic [3:0] awa, ara, lev;
  logic [31:0] wd, rd, v;
  logic [1:0] br, rr;
  int mismatches, comparisons;
  wire [3:0] go = {gd, gc, gb, ga};
  qgl_host_model u_host (.i_clk(clk), .i_levels(lev), .i_hold(hold), .o_level_a(la),
    .o_level_b(lb), .o_level_c(lc), .o_level_d(ld), .o_latch_gate_n(gate_n));
  qgl_top u_dut (.i_clk(clk), .i_rstn(rstn), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre),
    .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rd),
    .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .i_logic_level_a(la),
    .i_logic_level_b(lb), .i_logic_level_c(lc), .i_logic_level_d(ld), .i_latch_gate_n(gate_n),
    .i_supply_low(slow), .i_rail_ready_threshold(rdy), .i_rail_above_reg(abv),
    .o_gate_drive_a(ga), .o_gate_drive_b(gb), .o_gate_drive_c(gc), .o_gate_drive_d(gd),
    .o_power_good_flag(pg), .o_pump_enable(pump), .o_irq(irq));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic settle;
    repeat (6) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic aw_left, w_left, aw_go, w_go;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    // each channel is released at the edge that takes it
    while (aw_left || w_left) begin
      @(negedge clk);
      aw_go = aw_left && awr;
      w_go = w_left && wr;
      @(posedge clk);
      if (aw_go) awv <= 1'b0;
      if (w_go) wv <= 1'b0;
      aw_left = aw_left && !aw_go;
      w_left = w_left && !w_go;
    end
    @(negedge clk);
    while (!bv) @(negedge clk);
    check(br, QGL_RESP_OKAY);
    @(posedge clk);
    bre <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    @(negedge clk);
    while (!arr) @(negedge clk);
    @(posedge clk);
    arv <= 1'b0;
    @(negedge clk);
    while (!rv) @(negedge clk);
    d = rd;
    check(rr, QGL_RESP_OKAY);
    @(posedge clk);
    rre <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic sc_pass_hold;
    rd_reg(QGL_OFF_MASK, v);
    check(v, 32'h0);
    @(posedge clk);
    lev <= 4'h5;
    settle();
    check(go, 4'h5);
    rd_reg(QGL_OFF_STAT, v);
    check(v[6:0] & 7'h3f, 7'h25);
    @(posedge clk);
    hold <= 1'b1;
    settle();
    @(posedge clk);
    lev <= 4'ha;
    settle();
    check(go, 4'h5);
    @(posedge clk);
    hold <= 1'b0;
    settle();
    check(go, 4'ha);
  endtask
  task automatic sc_lockout;
    wr_reg(QGL_OFF_MASK, 32'h1);
    @(posedge clk);
    slow <= 1'b1;
    settle();
    check({irq, pg, go}, 6'h20);
    @(posedge clk);
    hold <= 1'b1;
    settle();
    // gate is already high when the supply recovers
    @(posedge clk);
    slow <= 1'b0;
    settle();
    check({pg, go}, 5'h10);
    wr_reg(QGL_OFF_MASK, 32'h0);
    check(irq, 1'b0);
    rd_reg(QGL_OFF_IRQ, v);
    check(v[0], 1'b1);
    wr_reg(QGL_OFF_IRQ, 32'h1);
    rd_reg(QGL_OFF_IRQ, v);
    check(v[0], 1'b0);
    @(posedge clk);
    hold <= 1'b0;
    settle();
    check(go, 4'ha);
    @(posedge clk);
    rdy <= 1'b0;
    settle();
    check({pg, go}, 5'h0);
    @(posedge clk);
    rdy <= 1'b1;
    settle();
    check({pg, go}, 5'h1a);
    wr_reg(QGL_OFF_CTRL, 32'h1);
    settle();
    check(go, 4'h0);
    wr_reg(QGL_OFF_CTRL, 32'h0);
    settle();
    check(go, 4'ha);
  endtask
  task automatic sc_pump;
    int n;
    n = 0;
    @(posedge clk);
    abv <= 1'b1;
    repeat (600) @(negedge clk);
    repeat (600) @(negedge clk) if (pump) n++;
    check(n, 0);
    rd_reg(QGL_OFF_IRQ, v);
    check(v[QGL_EV_SKIP_BIT], 1'b1);
    @(posedge clk);
    abv <= 1'b0;
    while (!pump) @(negedge clk);
    n = 0;
    while (pump) begin
      n++;
      @(negedge clk);
    end
    check(n, QGL_PUMP_HALF);
    while (!pump) begin
      n++;
      @(negedge clk);
    end
    check(n, QGL_PUMP_DIV);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0; awv = 1'b0; wv = 1'b0; bre = 1'b0; arv = 1'b0; rre = 1'b0;
    awa = 4'h0; ara = 4'h0; wd = 32'h0; lev = 4'h0; hold = 1'b0;
    slow = 1'b0; rdy = 1'b1; abv = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    settle();
    sc_pass_hold();
    sc_lockout();
    sc_pump();
    tally_and_finish();
  end
endmodule
`default_nettype wire
